// File: verilog/psb_pkg.sv
package psb_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int NCH     = 8;
  localparam int NCORE   = 2;
  localparam int IRQ_W   = 32;
  localparam int GPIO_W  = 14;
  localparam int HWE_W   = 28;
  localparam int TRIG_W  = 8;
  localparam int TRACE_W = 32;
  localparam int DBG_AW  = 16;
  localparam int APB_AW  = 8;
  localparam int DATA_W  = 32;

  // ************************************************************
  // fabric-side register map
  // ************************************************************
  localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DMA    = 8'h04;
  localparam logic [APB_AW-1:0] OFS_IRQ_LO = 8'h08;
  localparam logic [APB_AW-1:0] OFS_IRQ_HI = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] OFS_GPIO   = 8'h14;
  localparam logic [APB_AW-1:0] OFS_HWE    = 8'h18;
  localparam logic [APB_AW-1:0] OFS_TRIG   = 8'h1c;

  // control register bits
  localparam int CTL_COLD  = 0;
  localparam int CTL_WARM  = 1;
  localparam int CTL_DEBUG = 2;
  localparam int CTL_WAKE  = 3;
  localparam int CTL_CONF  = 4;
  localparam int CTL_PRE   = 5;
  localparam int CTL_FALL  = 6;
  localparam int CTL_TRACE = 7;

  // dma register fields and status bits
  localparam int DMA_BURST_LSB  = 0;
  localparam int DMA_SINGLE_LSB = 8;
  localparam int ST_BUSY_LSB    = 0;
  localparam int ST_EVWAIT_LSB  = 8;
  localparam int ST_IRQWAIT_LSB = 10;
  localparam int ST_EVENT       = 12;
  localparam int ST_WARM        = 13;

  // ************************************************************
  // link bundles
  // ************************************************************
  typedef struct packed {
    logic                 fabric_cold_reboot_request;
    logic                 fabric_warm_reboot_request;
    logic                 fabric_debug_reboot_request;
    logic                 warm_reboot_ack_n;
    logic [NCH-1:0]       dma_burst_request;
    logic [NCH-1:0]       dma_single_request;
    logic                 fabric_wake_event_in;
    logic [IRQ_W-1:0]     fabric_interrupts_high_word;
    logic [IRQ_W-1:0]     fabric_interrupts_low_word;
    logic                 fabric_preloader_available;
    logic                 fabric_fallback_preloader_available;
    logic [GPIO_W-1:0]    gpio_in;
    logic [HWE_W-1:0]     trace_hardware_event_inputs;
    logic [TRIG_W-1:0]    trig_in;
    logic [TRIG_W-1:0]    trig_out_ack;
    logic                 trace_clk_ctrl;
    logic                 dbg_psel;
    logic                 dbg_penable;
    logic                 dbg_pwrite;
    logic [DBG_AW-1:0]    dbg_paddr;
    logic [DATA_W-1:0]    dbg_pwdata;
  } psb_to_cpu_type;

  typedef struct packed {
    logic                 emac_tx_reset;
    logic                 emac_rx_reset;
    logic                 warm_reboot_pending_n;
    logic [NCH-1:0]       dma_request_acknowledge;
    logic                 cpu_send_event_out;
    logic [NCORE-1:0]     cores_waiting_for_event;
    logic [NCORE-1:0]     cores_waiting_for_interrupt;
    logic [TRIG_W-1:0]    trig_in_ack;
    logic [TRIG_W-1:0]    trig_out;
    logic [TRACE_W-1:0]   trace_port_output;
    logic [DATA_W-1:0]    dbg_prdata;
    logic                 dbg_pready;
  } psb_to_fab_type;

  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_REL} psb_hs_type;
  typedef enum logic [1:0] {DB_IDLE, DB_ACC, DB_DONE} psb_db_type;

endpackage

// File: verilog/psb_if.sv
`timescale 1ns/1ps
interface psb_if;
  import psb_pkg::*;
  psb_to_cpu_type to_cpu;
  psb_to_fab_type to_fab;
  modport device (input to_cpu, output to_fab);
  modport fabric (output to_cpu, input to_fab);
endinterface

// File: verilog/psb_sync.sv
`timescale 1ns/1ps
module psb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } psb_sync_state_type;

  psb_sync_state_type r_reg;
  psb_sync_state_type r_next;

  // first stage feeds only the second
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule

// File: verilog/psb_device.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module psb_device
  import psb_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       dbg_rst,
  psb_if.device                           link,
  input  wire logic                       emac_tx_reset_req,
  input  wire logic                       emac_rx_reset_req,
  input  wire logic                       warm_reset_start,
  input  wire logic [psb_pkg::NCORE-1:0]  core_send_event,
  input  wire logic [psb_pkg::NCORE-1:0]  core_event_wait,
  input  wire logic [psb_pkg::NCORE-1:0]  core_irq_wait,
  input  wire logic [psb_pkg::NCH-1:0]    dma_ctrl_ack,
  input  wire logic [psb_pkg::TRIG_W-1:0] trigger_to_fabric,
  input  wire logic [psb_pkg::TRACE_W-1:0] trace_word,
  input  wire logic                       trace_valid,
  input  wire logic [psb_pkg::DATA_W-1:0] dbg_int_prdata,
  input  wire logic                       dbg_int_pready,
  output logic                            cold_reset_pulse,
  output logic                            warm_reset_pulse,
  output logic                            debug_reset_pulse,
  output logic                            core_wake_pulse,
  output logic [2*psb_pkg::IRQ_W-1:0]     intc_interrupts,
  output logic                            preloader_ready,
  output logic                            fallback_ready,
  output logic [psb_pkg::GPIO_W-1:0]      gpio_inputs,
  output logic [psb_pkg::HWE_W-1:0]       trace_messages,
  output logic [psb_pkg::TRIG_W-1:0]      triggers_from_fabric,
  output logic [psb_pkg::NCH-1:0]         dma_ctrl_burst,
  output logic [psb_pkg::NCH-1:0]         dma_ctrl_single,
  output logic                            dbg_int_psel,
  output logic                            dbg_int_penable,
  output logic                            dbg_int_pwrite,
  output logic [psb_pkg::DBG_AW-1:0]      dbg_int_paddr,
  output logic [psb_pkg::DATA_W-1:0]      dbg_int_pwdata
);
  import psb_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                cold_q;
    logic                dbg_q;
    logic                warm_q;
    logic                wake_q;
    logic [HWE_W-1:0]    hwe_q;
    logic [TRIG_W-1:0]   trg_q;
    psb_hs_type          hs;
    psb_db_type          db;
    logic                cold_p;
    logic                warm_p;
    logic                debug_p;
    logic                wake_p;
    logic [2*IRQ_W-1:0]  intc;
    logic                pre;
    logic                fall;
    logic [GPIO_W-1:0]   gpio;
    logic [HWE_W-1:0]    msgs;
    logic [TRIG_W-1:0]   trig_from;
    logic [NCH-1:0]      burst;
    logic [NCH-1:0]      single;
    logic                ipsel;
    logic                ipen;
    logic                ipwrite;
    logic [DBG_AW-1:0]   ipaddr;
    logic [DATA_W-1:0]   ipwdata;
    psb_to_fab_type      o;
  } psb_dev_state_type;

  psb_dev_state_type r_reg;
  psb_dev_state_type r_next;
  psb_to_cpu_type    s;
  psb_to_cpu_type    idle_lvl;
  logic [$bits(psb_to_cpu_type)-1:0] s_raw;

  // ************************************************************
  // input synchroniser
  // ************************************************************
  // the whole fabric bundle is treated as asynchronous
  psb_sync #(
    .W ($bits(psb_to_cpu_type))
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (link.to_cpu ^ idle_lvl),
    .q   (s_raw)
  );

  // the acknowledge idles high; folding it through xor stops the zero reset
  // of the synchroniser from faking an acknowledge just after reset
  always_comb begin
    idle_lvl                   = '0;
    idle_lvl.warm_reboot_ack_n = 1'b1;
  end

  assign s = psb_to_cpu_type'(s_raw ^ idle_lvl);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    r_next        = r_reg;
    r_next.cold_q = s.fabric_cold_reboot_request;
    r_next.dbg_q  = s.fabric_debug_reboot_request;
    r_next.warm_q = s.fabric_warm_reboot_request;
    r_next.wake_q = s.fabric_wake_event_in;
    r_next.hwe_q  = s.trace_hardware_event_inputs;
    r_next.trg_q  = s.trig_in;

    // each request edge drives its own reset type
    r_next.cold_p  = s.fabric_cold_reboot_request & ~r_reg.cold_q;
    r_next.debug_p = s.fabric_debug_reboot_request & ~r_reg.dbg_q;
    r_next.warm_p  = 1'b0;

    // warm reset waits for the fabric to acknowledge the pending request
    case (r_reg.hs)
      HS_IDLE: begin
        if ((s.fabric_warm_reboot_request & ~r_reg.warm_q) | warm_reset_start) begin
          r_next.o.warm_reboot_pending_n = 1'b0;
          r_next.hs                      = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (!s.warm_reboot_ack_n) begin
          r_next.warm_p                  = 1'b1;
          r_next.o.warm_reboot_pending_n = 1'b1;
          r_next.hs                      = HS_REL;
        end
      end
      HS_REL: begin
        if (s.warm_reboot_ack_n) begin
          r_next.hs = HS_IDLE;
        end
      end
      default: begin
        r_next.hs = HS_IDLE;
      end
    endcase

    r_next.o.emac_tx_reset = emac_tx_reset_req;
    r_next.o.emac_rx_reset = emac_rx_reset_req;

    r_next.burst  = s.dma_burst_request;
    r_next.single = s.dma_single_request;
    r_next.o.dma_request_acknowledge = dma_ctrl_ack;

    // fabric wake merges with the cores' own send event path
    r_next.wake_p = (s.fabric_wake_event_in & ~r_reg.wake_q) | (|core_send_event);
    r_next.o.cpu_send_event_out          = |core_send_event;
    r_next.o.cores_waiting_for_event     = core_event_wait;
    r_next.o.cores_waiting_for_interrupt = core_irq_wait;

    r_next.intc = {s.fabric_interrupts_high_word, s.fabric_interrupts_low_word};
    r_next.pre  = s.fabric_preloader_available;
    r_next.fall = s.fabric_fallback_preloader_available;
    r_next.gpio = s.gpio_in;
    r_next.msgs = s.trace_hardware_event_inputs & ~r_reg.hwe_q;

    // four-phase trigger handshakes; a new trigger beats a same-cycle ack
    r_next.trig_from     = s.trig_in & ~r_reg.trg_q;
    r_next.o.trig_in_ack = s.trig_in;
    r_next.o.trig_out    = (r_reg.o.trig_out & ~s.trig_out_ack) | trigger_to_fabric;

    // trace word is only updated while the fabric enables the port
    if (s.trace_clk_ctrl & trace_valid) begin
      r_next.o.trace_port_output = trace_word;
    end

    // debug bridge: synchronised setup starts one internal transfer
    r_next.o.dbg_pready = 1'b0;
    case (r_reg.db)
      DB_IDLE: begin
        if (s.dbg_psel & ~s.dbg_penable) begin
          r_next.ipsel   = 1'b1;
          r_next.ipen    = 1'b0;
          r_next.ipwrite = s.dbg_pwrite;
          r_next.ipaddr  = s.dbg_paddr;
          r_next.ipwdata = s.dbg_pwdata;
          r_next.db      = DB_ACC;
        end
      end
      DB_ACC: begin
        r_next.ipen = 1'b1;
        if (r_reg.ipen & dbg_int_pready) begin
          r_next.ipsel        = 1'b0;
          r_next.ipen         = 1'b0;
          r_next.o.dbg_prdata = dbg_int_prdata;
          r_next.o.dbg_pready = 1'b1;
          r_next.db           = DB_DONE;
        end
      end
      DB_DONE: begin
        // synchronised penable lags; wait for it so one access is not run twice
        if (!s.dbg_penable) begin
          r_next.db = DB_IDLE;
        end
      end
      default: begin
        r_next.db = DB_IDLE;
      end
    endcase
    if (dbg_rst) begin
      r_next.db           = DB_IDLE;
      r_next.ipsel        = 1'b0;
      r_next.ipen         = 1'b0;
      r_next.o.dbg_pready = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg                         <= '0;
      r_reg.o.warm_reboot_pending_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign link.to_fab          = r_reg.o;
  assign cold_reset_pulse     = r_reg.cold_p;
  assign warm_reset_pulse     = r_reg.warm_p;
  assign debug_reset_pulse    = r_reg.debug_p;
  assign core_wake_pulse      = r_reg.wake_p;
  assign intc_interrupts      = r_reg.intc;
  assign preloader_ready      = r_reg.pre;
  assign fallback_ready       = r_reg.fall;
  assign gpio_inputs          = r_reg.gpio;
  assign trace_messages       = r_reg.msgs;
  assign triggers_from_fabric = r_reg.trig_from;
  assign dma_ctrl_burst       = r_reg.burst;
  assign dma_ctrl_single      = r_reg.single;
  assign dbg_int_psel         = r_reg.ipsel;
  assign dbg_int_penable      = r_reg.ipen;
  assign dbg_int_pwrite       = r_reg.ipwrite;
  assign dbg_int_paddr        = r_reg.ipaddr;
  assign dbg_int_pwdata       = r_reg.ipwdata;
endmodule

// File: verilog/psb_fabric.sv
`timescale 1ns/1ps
module psb_fabric
  import psb_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  psb_if.fabric                           link,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [psb_pkg::APB_AW-1:0] paddr,
  input  wire logic [psb_pkg::DATA_W-1:0] pwdata,
  output logic      [psb_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr
);
  import psb_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              configured;
    logic              ev_seen;
    logic              warm_seen;
    psb_to_cpu_type    o;
  } psb_fab_state_type;

  psb_fab_state_type r_reg;
  psb_fab_state_type r_next;
  psb_to_fab_type    h;
  logic [NCH-1:0]    busy;
  logic [DATA_W-1:0] ctrl_rd;
  logic              wr;

  assign h = link.to_fab;

  always_comb begin
    busy    = r_reg.o.dma_burst_request | r_reg.o.dma_single_request;
    ctrl_rd = '0;
    ctrl_rd[CTL_COLD]  = r_reg.o.fabric_cold_reboot_request;
    ctrl_rd[CTL_WARM]  = r_reg.o.fabric_warm_reboot_request;
    ctrl_rd[CTL_DEBUG] = r_reg.o.fabric_debug_reboot_request;
    ctrl_rd[CTL_CONF]  = r_reg.configured;
    ctrl_rd[CTL_PRE]   = r_reg.o.fabric_preloader_available;
    ctrl_rd[CTL_FALL]  = r_reg.o.fabric_fallback_preloader_available;
    ctrl_rd[CTL_TRACE] = r_reg.o.trace_clk_ctrl;
    // a write lands at the edge where pready is seen high
    wr = psel & penable & pwrite & r_reg.pready;

    r_next        = r_reg;
    r_next.pready = psel & penable & ~r_reg.pready;
    r_next.prdata = '0;
    if (psel & penable & ~r_reg.pready & ~pwrite) begin
      case (paddr)
        OFS_CTRL:   r_next.prdata = ctrl_rd;
        OFS_DMA:    r_next.prdata = DATA_W'({r_reg.o.dma_single_request,
                                             r_reg.o.dma_burst_request});
        OFS_IRQ_LO: r_next.prdata = r_reg.o.fabric_interrupts_low_word;
        OFS_IRQ_HI: r_next.prdata = r_reg.o.fabric_interrupts_high_word;
        OFS_STATUS: begin
          r_next.prdata[ST_BUSY_LSB +: NCH]  = busy;
          r_next.prdata[ST_EVWAIT_LSB +: NCORE]  = h.cores_waiting_for_event;
          r_next.prdata[ST_IRQWAIT_LSB +: NCORE] = h.cores_waiting_for_interrupt;
          r_next.prdata[ST_EVENT]            = r_reg.ev_seen;
          r_next.prdata[ST_WARM]             = r_reg.warm_seen;
        end
        OFS_GPIO:   r_next.prdata = DATA_W'(r_reg.o.gpio_in);
        OFS_HWE:    r_next.prdata = DATA_W'(r_reg.o.trace_hardware_event_inputs);
        OFS_TRIG:   r_next.prdata = DATA_W'(r_reg.o.trig_in);
        default:    r_next.prdata = '0;
      endcase
    end

    // requests drop once acknowledged
    r_next.o.dma_burst_request  = r_reg.o.dma_burst_request & ~h.dma_request_acknowledge;
    r_next.o.dma_single_request = r_reg.o.dma_single_request & ~h.dma_request_acknowledge;
    r_next.o.fabric_wake_event_in = 1'b0;

    // event flags: hardware set wins over software clear
    r_next.ev_seen   = r_reg.ev_seen | h.cpu_send_event_out;
    r_next.warm_seen = r_reg.warm_seen | ~h.warm_reboot_pending_n;

    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          r_next.o.fabric_cold_reboot_request  = pwdata[CTL_COLD];
          r_next.o.fabric_warm_reboot_request  = pwdata[CTL_WARM];
          r_next.o.fabric_debug_reboot_request = pwdata[CTL_DEBUG];
          r_next.configured                    = pwdata[CTL_CONF];
          // wake stays low until configuration is declared
          r_next.o.fabric_wake_event_in = pwdata[CTL_WAKE] & r_reg.configured;
          r_next.o.fabric_preloader_available          = pwdata[CTL_PRE];
          r_next.o.fabric_fallback_preloader_available = pwdata[CTL_FALL];
          r_next.o.trace_clk_ctrl = pwdata[CTL_TRACE];
        end
        OFS_DMA: begin
          // a channel starts only when idle and its acknowledge has cleared
          r_next.o.dma_burst_request = r_next.o.dma_burst_request |
            (pwdata[DMA_BURST_LSB +: NCH] & ~busy & ~h.dma_request_acknowledge);
          r_next.o.dma_single_request = r_next.o.dma_single_request |
            (pwdata[DMA_SINGLE_LSB +: NCH] & ~busy & ~h.dma_request_acknowledge);
        end
        OFS_IRQ_LO: r_next.o.fabric_interrupts_low_word  = pwdata;
        OFS_IRQ_HI: r_next.o.fabric_interrupts_high_word = pwdata;
        OFS_STATUS: begin
          r_next.ev_seen   = (r_reg.ev_seen & ~pwdata[ST_EVENT]) | h.cpu_send_event_out;
          r_next.warm_seen = (r_reg.warm_seen & ~pwdata[ST_WARM]) | ~h.warm_reboot_pending_n;
        end
        OFS_GPIO: r_next.o.gpio_in = pwdata[GPIO_W-1:0];
        OFS_HWE:  r_next.o.trace_hardware_event_inputs = pwdata[HWE_W-1:0];
        OFS_TRIG: r_next.o.trig_in = pwdata[TRIG_W-1:0];
        default: begin
        end
      endcase
    end

    r_next.o.warm_reboot_ack_n = h.warm_reboot_pending_n;
    r_next.o.trig_out_ack      = h.trig_out;
    r_next.o.dbg_psel          = 1'b0;
    r_next.o.dbg_penable       = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg                     <= '0;
      r_reg.o.warm_reboot_ack_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.to_cpu = r_reg.o;
  assign prdata      = r_reg.prdata;
  assign pready      = r_reg.pready;
  assign pslverr     = 1'b0;
endmodule

// File: bench/psb_chk.sv
`timescale 1ns/1ps
// ************************************************************
// link checks between fabric and device ends
// ************************************************************
module psb_chk
  import psb_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rst,
  input wire psb_pkg::psb_to_cpu_type  to_cpu,
  input wire psb_pkg::psb_to_fab_type  to_fab
);
  import psb_pkg::*;
  logic [NCH-1:0] req;
  logic [NCH-1:0] ack;
  logic           pend_n;
  assign req    = to_cpu.dma_burst_request | to_cpu.dma_single_request;
  assign ack    = to_fab.dma_request_acknowledge;
  assign pend_n = to_fab.warm_reboot_pending_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_wake_one_cycle: assert property (to_cpu.fabric_wake_event_in |=> !to_cpu.fabric_wake_event_in)
    else $error("wake input longer than one cycle");
  a_req_drops_ack: assert property (|(req & ack) |=> (req & $past(req & ack)) == '0)
    else $error("request kept after acknowledge");
  // an unanswered request must not vanish, or the transfer is lost
  a_req_held_wait: assert property (|(req & ~ack) |=> (req & $past(req & ~ack)) == $past(req & ~ack))
    else $error("request dropped before acknowledge");
  a_pend_ack_follow: assert property ($fell(pend_n) |=> !to_cpu.warm_reboot_ack_n)
    else $error("pending not acknowledged next cycle");
  a_pend_hold_bound: assert property ($fell(pend_n) |-> !pend_n [*3] ##[1:6] pend_n)
    else $error("pending request timing wrong");
  a_ack_release: assert property ($rose(pend_n) |=> to_cpu.warm_reboot_ack_n)
    else $error("acknowledge not released");
  a_trig_in_ack: assert property ($rose(to_cpu.trig_in[0]) |-> ##[2:3] to_fab.trig_in_ack[0])
    else $error("trigger input not acknowledged");
  a_trig_out_ack: assert property ($rose(to_fab.trig_out[0]) |=> to_cpu.trig_out_ack[0])
    else $error("trigger output not acknowledged");
  a_trig_out_clear: assert property ($rose(to_fab.trig_out[0]) |-> ##[1:6] !to_fab.trig_out[0])
    else $error("trigger output never cleared");
endmodule

// File: bench/psb_tb.sv
`timescale 1ns/1ps
// ************************************************************
// both ends joined, driven from the register side and through the device-side inputs
// ************************************************************
module testbench;
  import psb_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        emac_tx_reset_req = 1'b0, emac_rx_reset_req = 1'b0, warm_reset_start = 1'b0;
  logic        pready, pslverr, cold_reset_pulse, warm_reset_pulse, debug_reset_pulse;
  logic        core_wake_pulse, preloader_ready, fallback_ready, trace_valid = 1'b0;
  logic [1:0]  core_send_event = '0, core_event_wait = '0, core_irq_wait = '0;
  logic [7:0]  paddr = '0, dma_ctrl_ack = '0, trigger_to_fabric = '0, trig_seen = '0;
  logic [7:0]  triggers_from_fabric, dma_ctrl_burst, dma_ctrl_single;
  logic [31:0] pwdata = '0, prdata, rd, trace_word = '0;
  logic [63:0] intc_interrupts;
  logic [13:0] gpio_inputs;
  logic [27:0] trace_messages, hwe_seen = '0;
  int          num_errors = 0, total_checks = 0, n_cold = 0, n_warm = 0, n_dbg = 0, n_wake = 0;
  psb_if i_psb_if ();
  psb_device i_psb_device (
    .clk, .rst, .dbg_rst(1'b0), .link(i_psb_if.device), .emac_tx_reset_req, .emac_rx_reset_req,
    .warm_reset_start, .core_send_event, .core_event_wait, .core_irq_wait, .dma_ctrl_ack,
    .trigger_to_fabric, .trace_word, .trace_valid, .dbg_int_prdata('0),
    .dbg_int_pready(1'b0), .cold_reset_pulse, .warm_reset_pulse, .debug_reset_pulse,
    .core_wake_pulse, .intc_interrupts, .preloader_ready, .fallback_ready, .gpio_inputs,
    .trace_messages, .triggers_from_fabric, .dma_ctrl_burst, .dma_ctrl_single, .dbg_int_psel(),
    .dbg_int_penable(), .dbg_int_pwrite(), .dbg_int_paddr(), .dbg_int_pwdata());
  psb_fabric i_psb_fabric (.clk, .rst, .link(i_psb_if.fabric), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  psb_chk i_psb_chk (.clk, .rst, .to_cpu(i_psb_if.to_cpu), .to_fab(i_psb_if.to_fab));
  always #12.5 clk = ~clk;
  // running totals avoid clearing counters from a second process
  always @(posedge clk) begin
    n_cold += int'(cold_reset_pulse);
    n_warm += int'(warm_reset_pulse);
    n_dbg += int'(debug_reset_pulse);
    n_wake += int'(core_wake_pulse);
    hwe_seen |= trace_messages;
    trig_seen |= triggers_from_fabric;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk) k++; while (pready !== 1'b1 && k < 9);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up;
    end else begin
      rd = prdata;
      {psel, penable} <= 2'b00;
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(nm, e, rd);
  endtask
  task automatic t_boot_wake;
    apb(1'b1, OFS_CTRL, 32'h8);
    idle(8);
    chk("wake unconfigured", 64'h0, n_wake);
    apb(1'b1, OFS_CTRL, 32'h70);
    apb(1'b1, OFS_CTRL, 32'h78);
    idle(8);
    chk("wake", 64'h1, n_wake);
    chk("boot flags", 64'h3, {preloader_ready, fallback_ready});
  endtask
  task automatic t_resets;
    apb(1'b1, OFS_CTRL, 32'h75);
    idle(8);
    apb(1'b1, OFS_CTRL, 32'h72);
    idle(16);
    @(posedge clk) warm_reset_start <= 1'b1;
    @(posedge clk) warm_reset_start <= 1'b0;
    idle(16);
    chk("resets", {16'h1, 16'h1, 16'h2}, {n_cold[15:0], n_dbg[15:0], n_warm[15:0]});
  endtask
  task automatic t_dma;
    apb(1'b1, OFS_DMA, 32'h2008);
    idle(4);
    chk("dma lines", 64'h2008, {dma_ctrl_single, dma_ctrl_burst});
    rdc("dma held", OFS_DMA, 32'h2008);
    @(posedge clk) dma_ctrl_ack <= 8'h28;
    idle(8);
    chk("dma ack", 64'h28, i_psb_if.to_fab.dma_request_acknowledge);
    chk("dma dropped", 64'h0, {dma_ctrl_single, dma_ctrl_burst});
    @(posedge clk) dma_ctrl_ack <= 8'h00;
    idle(4);
  endtask
  task automatic t_status;
    @(posedge clk) {core_send_event, core_event_wait, core_irq_wait} <= 6'h19;
    @(posedge clk) core_send_event <= 2'h0;
    idle(8);
    rdc("status", OFS_STATUS, 32'h3600);
    apb(1'b1, OFS_STATUS, 32'h3000);
    rdc("status cleared", OFS_STATUS, 32'h0600);
  endtask
  task automatic t_misc;
    apb(1'b1, OFS_IRQ_LO, 32'h80000001);
    apb(1'b1, OFS_IRQ_HI, 32'h40000002);
    apb(1'b1, OFS_GPIO, 32'hffffea5b);
    apb(1'b1, OFS_HWE, 32'h08000005);
    apb(1'b1, OFS_TRIG, 32'h81);
    apb(1'b1, 8'h20, 32'hffffffff);
    @(posedge clk) {emac_tx_reset_req, trigger_to_fabric} <= 9'h101;
    @(posedge clk) trigger_to_fabric <= 8'h00;
    idle(8);
    chk("irq", 64'h4000000280000001, intc_interrupts);
    chk("gpio", 64'h2a5b, gpio_inputs);
    rdc("gpio word", OFS_GPIO, 32'h2a5b);
    chk("hw events", 64'h8000005, hwe_seen);
    chk("triggers", 64'h81, trig_seen);
    chk("emac", 64'h2, {i_psb_if.to_fab.emac_tx_reset, i_psb_if.to_fab.emac_rx_reset});
    rdc("unmapped", 8'h20, 32'h0);
    chk("slave error", 64'h0, pslverr);
  endtask
  // trace word must not pass while the fabric keeps the port disabled
  task automatic t_trace;
    @(posedge clk) {trace_valid, trace_word} <= {1'b1, 32'h5a5a0001};
    idle(6);
    chk("trace gated", 64'h0, i_psb_if.to_fab.trace_port_output);
    apb(1'b1, OFS_CTRL, 32'hf0);
    rdc("ctrl word", OFS_CTRL, 32'hf0);
    idle(2);
    chk("trace word", 64'h5a5a0001, i_psb_if.to_fab.trace_port_output);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    chk("idle n", 64'h3, {i_psb_if.to_fab.warm_reboot_pending_n, i_psb_if.to_cpu.warm_reboot_ack_n});
    t_boot_wake;
    t_resets;
    t_dma;
    t_status;
    t_misc;
    t_trace;
    wrap_up;
  end
endmodule
